// *** afd_pkg.sv ***
/*
  Constants shared by the automatic fan duty loop: register offsets,
  reset values, field positions, duty scaling and spin-up timing.
  Assumes a 200 MHz system clock and whole-degree Celsius temperatures.
*/
package afd_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_TRAITS = 8'h20;
  localparam logic [7:0] ADDR_FLOOR = 8'h22;
  localparam logic [7:0] ADDR_LOCAL = 8'h24;
  localparam logic [7:0] ADDR_REMOTE = 8'h25;
  localparam logic [7:0] ADDR_MANUAL = 8'h30;
  localparam logic [7:0] ADDR_STATUS = 8'h31;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_MODE = 8'h80;
  localparam logic [7:0] RST_TRAITS = 8'h1D;
  localparam logic [7:0] RST_FLOOR = 8'h05;
  localparam logic [7:0] RST_LOCAL = 8'h44;
  localparam logic [7:0] RST_REMOTE = 8'h44;
  localparam logic [7:0] RST_MANUAL = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_AUTO_BIT = 7;
  localparam int SEL_HI_BIT = 6;
  localparam int SEL_LO_BIT = 5;
  localparam logic [1:0] SEL_BOTH = 2'h3;
  localparam int SPIN_HI_BIT = 2;
  localparam int FLOOR_HI_BIT = 3;
  localparam int TMIN_HI_BIT = 7;
  localparam int TMIN_LO_BIT = 3;
  localparam int RANGE_HI_BIT = 2;

  // ----------------------------------------------------------------
  // Duty scaling: 240 slots per period, 16 slots per floor code
  // ----------------------------------------------------------------
  localparam logic [7:0] FULL_SLOTS = 8'hF0;
  localparam int SLOTS_PER_CODE_LOG2 = 4;
  localparam logic [5:0] SLOPE_BASE = 6'h20;
  localparam logic [7:0] HYST_C = 8'h05;
  localparam int TMIN_STEP_LOG2 = 2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [13:0] SPIN_MS_0 = 14'h00C8;
  localparam logic [13:0] SPIN_MS_1 = 14'h0190;
  localparam logic [13:0] SPIN_MS_2 = 14'h0258;
  localparam logic [13:0] SPIN_MS_3 = 14'h0320;
  localparam logic [13:0] SPIN_MS_4 = 14'h03E8;
  localparam logic [13:0] SPIN_MS_5 = 14'h07D0;
  localparam logic [13:0] SPIN_MS_6 = 14'h0FA0;
  localparam logic [13:0] SPIN_MS_7 = 14'h1F40;

  typedef enum logic [1:0] {PH_OFF, PH_SPIN, PH_RUN} afd_phase_t;

  function automatic logic [13:0] afd_spin_ms(input logic [2:0] code);
    logic [13:0] ms;
    ms = SPIN_MS_5;
    case (code)
      3'h0: ms = SPIN_MS_0;
      3'h1: ms = SPIN_MS_1;
      3'h2: ms = SPIN_MS_2;
      3'h3: ms = SPIN_MS_3;
      3'h4: ms = SPIN_MS_4;
      3'h5: ms = SPIN_MS_5;
      3'h6: ms = SPIN_MS_6;
      default: ms = SPIN_MS_7;
    endcase
    return ms;
  endfunction

endpackage

// *** afd_loop_if.sv ***
/*
  Carrier between the top and one temperature channel loop.
  Assumes both ends share the system clock.
*/
interface afd_loop_if;
  logic [4:0] tmin_code;
  logic [2:0] range_code;
  logic [3:0] floor_code;
  logic [7:0] temp;
  logic on;
  logic [7:0] duty;
  modport cfg (output tmin_code, range_code, floor_code, temp, input on, duty);
  modport loop (input tmin_code, range_code, floor_code, temp, output on, duty);
endinterface

// *** afd_loop.sv ***
/*
  One channel control loop: hysteretic turn-on and linear duty slope.
  Assumes temperature comes from logic on the same clock.
*/
module afd_loop
  import afd_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic rstn,
  // Channel
  afd_loop_if.loop lp
);
  import afd_pkg::*;

  typedef struct packed {
    logic on;
    logic [7:0] duty;
  } afd_loop_state_t;

  afd_loop_state_t state;
  afd_loop_state_t next_state;
  logic [7:0] tmin;
  logic [7:0] floor_slots;
  logic [5:0] slope;
  logic [7:0] delta;
  logic [13:0] rise;
  logic [14:0] sum;

  always_comb
  begin
    tmin = {1'b0, lp.tmin_code, 2'b00};
    floor_slots = {lp.floor_code, 4'h0};
    // Slots per degree is 160 over the range; codes above 80 C act as 80 C
    slope = (lp.range_code > 3'h4) ? 6'h02 : (SLOPE_BASE >> lp.range_code);
    delta = lp.temp - tmin;
    rise = 14'(delta) * 14'(slope);
    sum = {7'h00, floor_slots} + {1'b0, rise};
    next_state = state;
    if (!state.on && (lp.temp > tmin))
    begin
      next_state.on = 1'b1;
    end
    else if (state.on && ({1'b0, lp.temp} + {1'b0, HYST_C} < {1'b0, tmin}))
    begin
      next_state.on = 1'b0;
    end
    if (!next_state.on)
    begin
      next_state.duty = 8'h00;
    end
    else if (lp.temp <= tmin)
    begin
      next_state.duty = floor_slots;
    end
    else if (sum >= {7'h00, FULL_SLOTS})
    begin
      next_state.duty = FULL_SLOTS;
    end
    else
    begin
      next_state.duty = sum[7:0];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      state <= '0;
    else
      state <= next_state;
  end

  assign lp.on = state.on;
  assign lp.duty = state.duty;

endmodule

// *** afd_top.sv ***
/*
  Automatic fan duty loop top: register file, channel selection,
  spin-up timing and the final duty in 1/240 slots.
  Assumes temperatures and register strobes come from the same clock;
  the PWM waveform generator sits outside and consumes duty_slots.
*/
//
// Operation
// - Above turn-on temperature, start at floor duty
// - Spin-up interval precedes temperature-derived duty
// - Spin-up code selects 200 ms to 8 s
// - Mode bit 7 selects automatic or software duty
// - Reset leaves automatic mode active
// - Select 00 uses remote loop only
// - Select 11 uses larger of both loops
// - Each loop has own threshold and range; floor code is shared
// - Fastest duty wins, not hottest channel
// - Floor duty field sets duty at threshold
// - Floor codes 0..15 scale linearly to 100%
// - Full duty at threshold plus (15-code)*range/10
// - Linear rise to full, then hold full
// - Turn-on temperature in 4 C steps
// - Range codes give 5 to 80 C
// - Stay on until 5 C below threshold
// - Local pair at 0x24, remote at 0x25
module afd_top
  import afd_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
)
(
  // System
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Temperatures in whole degrees C
  input wire logic [7:0] local_temp,
  input wire logic [7:0] remote_temp,
  // Fan drive
  output logic [7:0] duty_slots,
  output logic fan_running,
  output logic spin_active
);
  import afd_pkg::*;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] traits;
    logic [7:0] floor;
    logic [7:0] local_cfg;
    logic [7:0] remote_cfg;
    logic [7:0] manual;
    afd_phase_t phase;
    logic [17:0] tick;
    logic [13:0] spin;
    logic [7:0] duty;
    logic [7:0] rdata;
  } afd_top_state_t;

  localparam afd_top_state_t RST_STATE = '{
    mode: RST_MODE, traits: RST_TRAITS, floor: RST_FLOOR,
    local_cfg: RST_LOCAL, remote_cfg: RST_REMOTE, manual: RST_MANUAL,
    phase: PH_OFF, tick: 18'h00000, spin: 14'h0000, duty: 8'h00, rdata: 8'h00};

  afd_top_state_t state;
  afd_top_state_t next_state;
  afd_loop_if local_lp ();
  afd_loop_if remote_lp ();
  logic auto_mode;
  logic want_on;
  logic [7:0] loop_duty;
  logic tick_hit;

  // ----------------------------------------------------------------
  // Channel loops
  // ----------------------------------------------------------------
  assign local_lp.tmin_code = state.local_cfg[TMIN_HI_BIT:TMIN_LO_BIT];
  assign local_lp.range_code = state.local_cfg[RANGE_HI_BIT:0];
  assign local_lp.floor_code = state.floor[FLOOR_HI_BIT:0];
  assign local_lp.temp = local_temp;
  assign remote_lp.tmin_code = state.remote_cfg[TMIN_HI_BIT:TMIN_LO_BIT];
  assign remote_lp.range_code = state.remote_cfg[RANGE_HI_BIT:0];
  assign remote_lp.floor_code = state.floor[FLOOR_HI_BIT:0];
  assign remote_lp.temp = remote_temp;

  afd_loop u_local (
    .clk(clk),
    .rstn(rstn),
    .lp(local_lp)
  );

  afd_loop u_remote (
    .clk(clk),
    .rstn(rstn),
    .lp(remote_lp)
  );

  // ----------------------------------------------------------------
  // Channel selection
  // ----------------------------------------------------------------
  always_comb
  begin
    auto_mode = state.mode[MODE_AUTO_BIT];
    // Codes 01 and 10 are undefined; they fall back to the remote loop
    if (state.mode[SEL_HI_BIT:SEL_LO_BIT] == SEL_BOTH)
    begin
      want_on = local_lp.on | remote_lp.on;
      // Compare duties, never temperatures
      loop_duty = (local_lp.duty > remote_lp.duty) ? local_lp.duty : remote_lp.duty;
    end
    else
    begin
      want_on = remote_lp.on;
      loop_duty = remote_lp.duty;
    end
  end

  assign tick_hit = (state.tick == 18'(TICK_LEN - 1));

  // ----------------------------------------------------------------
  // Registers and spin-up sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_state.tick = tick_hit ? 18'h00000 : state.tick + 18'h00001;
    if (reg_wr)
    begin
      if (reg_addr == ADDR_MODE)
        next_state.mode = reg_wdata;
      else if (reg_addr == ADDR_TRAITS)
        next_state.traits = reg_wdata;
      else if (reg_addr == ADDR_FLOOR)
        next_state.floor = reg_wdata;
      else if (reg_addr == ADDR_LOCAL)
        next_state.local_cfg = reg_wdata;
      else if (reg_addr == ADDR_REMOTE)
        next_state.remote_cfg = reg_wdata;
      else if (reg_addr == ADDR_MANUAL)
        next_state.manual = reg_wdata;
    end
    if (reg_rd)
    begin
      if (reg_addr == ADDR_MODE)
        next_state.rdata = state.mode;
      else if (reg_addr == ADDR_TRAITS)
        next_state.rdata = state.traits;
      else if (reg_addr == ADDR_FLOOR)
        next_state.rdata = state.floor;
      else if (reg_addr == ADDR_LOCAL)
        next_state.rdata = state.local_cfg;
      else if (reg_addr == ADDR_REMOTE)
        next_state.rdata = state.remote_cfg;
      else if (reg_addr == ADDR_MANUAL)
        next_state.rdata = state.manual;
      else if (reg_addr == ADDR_STATUS)
        next_state.rdata = state.duty;
      else
        next_state.rdata = 8'h00;
    end
    if (!auto_mode)
    begin
      next_state.phase = PH_OFF;
      // Manual duty uses the same 16-slot code scale as the floor
      next_state.duty = {state.manual[FLOOR_HI_BIT:0], 4'h0};
    end
    else
    begin
      case (state.phase)
        PH_OFF:
        begin
          next_state.duty = 8'h00;
          if (want_on)
          begin
            next_state.phase = PH_SPIN;
            next_state.spin = afd_spin_ms(state.traits[SPIN_HI_BIT:0]);
            next_state.tick = 18'h00000;
            next_state.duty = FULL_SLOTS;
          end
        end
        PH_SPIN:
        begin
          next_state.duty = FULL_SLOTS;
          if (!want_on)
          begin
            next_state.phase = PH_OFF;
            next_state.duty = 8'h00;
          end
          else if (tick_hit)
          begin
            next_state.spin = state.spin - 14'h0001;
            if (state.spin == 14'h0001)
            begin
              next_state.phase = PH_RUN;
              next_state.duty = loop_duty;
            end
          end
        end
        PH_RUN:
        begin
          next_state.duty = want_on ? loop_duty : 8'h00;
          if (!want_on)
            next_state.phase = PH_OFF;
        end
        default:
        begin
          next_state.phase = PH_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      state <= RST_STATE;
    else
      state <= next_state;
  end

  assign reg_rdata = state.rdata;
  assign duty_slots = state.duty;
  assign fan_running = (state.phase != PH_OFF);
  assign spin_active = (state.phase == PH_SPIN);

endmodule

// *** afd_fan_model.sv ***
/*
  Behavioural PWM fan: speed slews toward the drive in 1/240 slots.
  Assumes the drive comes from the system clock domain.
*/
module afd_fan_model #(
  parameter int STEP = 1
)
(
  // System
  input wire logic clk,
  input wire logic rstn,
  // Drive and modelled speed
  input wire logic [7:0] duty,
  output logic [7:0] speed
);
  timeunit 1ns;
  timeprecision 1ps;
  // Rotor inertia: a large STEP answers promptly, STEP 1 slowly
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      speed <= 8'h00;
    else if (duty > speed)
      speed <= (duty - speed > 8'(STEP)) ? speed + 8'(STEP) : duty;
    else
      speed <= (speed - duty > 8'(STEP)) ? speed - 8'(STEP) : duty;
endmodule

// *** afd_checker_properties.sv ***
/*
  Port checks for afd_top, bound into every instance.
  Assumes register writes take effect at the strobe edge.
*/
module afd_checker
  import afd_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
)
(
  // System
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Temperatures
  input wire logic [7:0] local_temp,
  input wire logic [7:0] remote_temp,
  // Fan drive
  input wire logic [7:0] duty_slots,
  input wire logic fan_running,
  input wire logic spin_active
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SPIN_MS [8] = '{200, 400, 600, 800, 1000, 2000, 4000, 8000};
  logic [7:0] mode_q;
  logic [7:0] rem_q;
  logic [3:0] floor_q;
  logic [3:0] man_q;
  logic [2:0] spin_q;
  int cnt_q;
  int len;
  assign len = SPIN_MS[spin_q] * TICK_LEN;
  // Shadow copies, so checks need no view inside the block
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      mode_q <= RST_MODE;
      rem_q <= RST_REMOTE;
      floor_q <= RST_FLOOR[3:0];
      man_q <= RST_MANUAL[3:0];
      spin_q <= RST_TRAITS[2:0];
      cnt_q <= 0;
    end
    else
    begin
      cnt_q <= spin_active ? cnt_q + 1 : 0;
      if (reg_wr)
      begin
        case (reg_addr)
          ADDR_MODE: mode_q <= reg_wdata;
          ADDR_REMOTE: rem_q <= reg_wdata;
          ADDR_FLOOR: floor_q <= reg_wdata[3:0];
          ADDR_MANUAL: man_q <= reg_wdata[3:0];
          ADDR_TRAITS: spin_q <= reg_wdata[2:0];
          default: ;
        endcase
      end
    end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  spin_full_a: assert property (spin_active |-> duty_slots == FULL_SLOTS)
    else $error("spin-up duty not full");
  spin_first_a: assert property ($rose(fan_running) |-> spin_active)
    else $error("fan started without spin-up");
  spin_len_a: assert property ($fell(spin_active) && fan_running |-> cnt_q == len)
    else $error("spin-up length wrong");
  floor_min_a: assert property (mode_q[7] && fan_running && $past(floor_q, 2) == floor_q
    |-> duty_slots >= {floor_q, 4'h0})
    else $error("duty below floor");
  off_zero_a: assert property (mode_q[7] && $past(mode_q[7], 2) && !fan_running
    |-> duty_slots == 8'h00)
    else $error("idle fan driven");
  remote_on_a: assert property (mode_q[7:5] == 3'h4 && remote_temp > {rem_q[7:3], 2'h0}
    && $stable(remote_temp) |-> ##[0:3] fan_running)
    else $error("remote loop did not start fan");
  sw_duty_a: assert property (reg_wr && reg_addr == ADDR_MANUAL && !mode_q[7]
    |=> ##[0:1] duty_slots == {man_q, 4'h0})
    else $error("software duty not applied");
  unmapped_rd_a: assert property (reg_rd && !(reg_addr inside {8'h00, 8'h20, 8'h22, 8'h24, 8'h25, 8'h30, 8'h31})
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
endmodule

bind afd_top afd_checker #(.TICK_LEN(TICK_LEN)) u_afd_checker (
  .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .local_temp(local_temp), .remote_temp(remote_temp), .duty_slots(duty_slots),
  .fan_running(fan_running), .spin_active(spin_active)
);

// *** afd_top_tb.sv ***
/*
  Self-checking bench for afd_top with a fan model on the drive.
  Assumes TICK_LEN 1, so a spin code of 2 s lasts 2000 cycles.
*/
module afd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import afd_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] local_temp = 8'h00;
  logic [7:0] remote_temp = 8'h14;
  logic [7:0] reg_rdata;
  logic [7:0] duty_slots;
  logic [7:0] fan_speed;
  logic fan_running;
  logic spin_active;
  int n_mismatch = 0;
  int check_count = 0;
  int spin_n = 0;
  int spin_last = 0;

  always #2.5 clk = ~clk;

  afd_top #(.TICK_LEN(1)) DUT (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .local_temp(local_temp), .remote_temp(remote_temp), .duty_slots(duty_slots),
    .fan_running(fan_running), .spin_active(spin_active)
  );
  afd_fan_model u_fan (.clk(clk), .rstn(rstn), .duty(duty_slots), .speed(fan_speed));

  // Length of the latest spin-up, in cycles
  always @(negedge clk)
    if (spin_active === 1'b1)
      spin_n++;
    else if (spin_n != 0)
    begin
      spin_last = spin_n;
      spin_n = 0;
    end

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(16'(reg_rdata), 16'(exp));
  endtask

  // Loop plus top take two edges; four leaves margin
  task automatic temps(input logic [7:0] l, input logic [7:0] r, input logic [7:0] exp);
    @(negedge clk);
    local_temp = l;
    remote_temp = r;
    repeat (4) @(negedge clk);
    chk(16'(duty_slots), 16'(exp));
  endtask

  task automatic spun(input int len);
    for (int i = 0; i < 10 && spin_active !== 1'b1; i++)
      @(negedge clk);
    if (spin_active !== 1'b1)
    begin
      n_mismatch++;
      $display("ERROR %0t spin-up never started", $time);
      test_done;
    end
    for (int i = 0; spin_active !== 1'b0; i++)
    begin
      if (i > 9000)
      begin
        n_mismatch++;
        test_done;
      end
      @(negedge clk);
    end
    if (len > 240)
      chk(16'(fan_speed), 16'h00F0);
    @(negedge clk);
    chk(16'(spin_last), 16'(len));
  endtask

  initial
  begin
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    rd(ADDR_MODE, 8'h80);
    rd(ADDR_TRAITS, 8'h1D);
    rd(ADDR_FLOOR, 8'h05);
    rd(ADDR_LOCAL, 8'h44);
    rd(ADDR_REMOTE, 8'h44);
    rd(8'h7F, 8'h00);
    temps(8'h40, 8'h20, 8'h00);
    temps(8'h40, 8'h21, 8'hF0);
    spun(2000);
    temps(8'h40, 8'h21, 8'h52);
    temps(8'h40, 8'h1C, 8'h50);
    chk(16'(fan_running), 16'h0001);
    temps(8'h40, 8'h1A, 8'h00);
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_MANUAL, 8'h0A);
    temps(8'h40, 8'h1A, 8'hA0);
    rd(ADDR_MANUAL, 8'h0A);
    wr(ADDR_TRAITS, 8'h18);
    wr(ADDR_REMOTE, 8'h03);
    wr(ADDR_FLOOR, 8'h08);
    wr(ADDR_LOCAL, 8'h2B);
    wr(ADDR_MODE, 8'h80);
    spun(200);
    temps(8'h40, 8'h01, 8'h84);
    temps(8'h40, 8'h1B, 8'hEC);
    temps(8'h40, 8'h1C, 8'hF0);
    temps(8'h40, 8'h3C, 8'hF0);
    for (int f = 0; f < 16; f++)
    begin
      wr(ADDR_FLOOR, 8'(f));
      temps(8'h40, 8'h00, 8'(f * 16));
    end
    wr(ADDR_FLOOR, 8'h05);
    wr(ADDR_REMOTE, 8'h04);
    wr(ADDR_MODE, 8'hE0);
    temps(8'h28, 8'h28, 8'hA0);
    temps(8'h3C, 8'h46, 8'hF0);
    temps(8'h14, 8'h14, 8'h78);
    temps(8'h3A, 8'h46, 8'hE8);
    wr(ADDR_MODE, 8'h80);
    temps(8'h3A, 8'h46, 8'hDC);
    rd(ADDR_STATUS, 8'hDC);
    // Undefined select code 01 must still follow the remote loop only
    wr(ADDR_MODE, 8'hA0);
    temps(8'h3C, 8'h46, 8'hDC);
    test_done;
  end
endmodule
